// file: core/nnop_consts.svh
`ifndef NNOP_CONSTS_SVH
`define NNOP_CONSTS_SVH

// ----------------------------------------
// Opcode bytes
// ----------------------------------------
`define NNOP_OP_NOP      8'h90
`define NNOP_OP_GRP3_B   8'hf6
`define NNOP_OP_GRP3_V   8'hf7
`define NNOP_OP_OR_RM_B  8'h08
`define NNOP_OP_OR_RM_V  8'h09
`define NNOP_OP_OR_R_B   8'h0a
`define NNOP_OP_OR_R_V   8'h0b
`define NNOP_OP_OR_A_B   8'h0c
`define NNOP_OP_OR_A_V   8'h0d
`define NNOP_OP_GRP1_B   8'h80
`define NNOP_OP_GRP1_V   8'h81
`define NNOP_OP_GRP1_SX  8'h83
`define NNOP_OP_OUT_I_B  8'he6
`define NNOP_OP_OUT_I_V  8'he7
`define NNOP_OP_OUT_D_B  8'hee
`define NNOP_OP_OUT_D_V  8'hef
`define NNOP_EXT_NOT     3'h2
`define NNOP_EXT_OR      3'h1
`define NNOP_CPL_USER    2'h3
`define NNOP_ERR_ZERO    32'h0000_0000

// ----------------------------------------
// Register offsets and bits
// ----------------------------------------
`define NNOP_REG_CTRL    8'h00
`define NNOP_REG_STATUS  8'h04
`define NNOP_REG_MASK    8'h08
`define NNOP_REG_RETIRED 8'h0c
`define NNOP_REG_FAULT   8'h10
`define NNOP_REG_IOADDR  8'h14
`define NNOP_CTRL_EN     0
`define NNOP_ST_RETIRE   0
`define NNOP_ST_FAULT    1
`define NNOP_ST_IOWR     2
`define NNOP_ST_UNCLAIM  3
`define NNOP_CTRL_RST    1'b1
`define NNOP_MASK_RST    4'h0

`endif

// file: core/nnop_pkg.sv
package nnop_pkg;
  typedef enum logic [2:0] {OPC_NONE, OPC_NOP, OPC_NOT, OPC_OR, OPC_OUT} nnop_class_t;
  typedef enum logic [1:0] {W_BYTE, W_WORD, W_DWORD} nnop_width_t;
  typedef enum logic [2:0] {FLT_NONE, FLT_GP, FLT_SS, FLT_PF, FLT_AC} nnop_vec_t;

  typedef struct packed {
    logic        overflow_flag;
    logic        carry_flag;
    logic        sign_flag;
    logic        zero_flag;
    logic        parity_flag;
    logic        aux_carry_flag;
  } nnop_flags_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  ext;        // Modrm reg field
    logic        opsize32;
    logic        rm_is_mem;
    logic [31:0] rm_val;
    logic [31:0] reg_val;
    logic [31:0] acc_val;
    logic [31:0] imm;
    logic [15:0] data_count_register;
  } nnop_req_t;

  typedef struct packed {
    logic        protection_enable;
    logic        virtual8086_flag;
    logic [1:0]  current_privilege;
    logic [1:0]  io_privilege_level;
    logic        align_check_en;
  } nnop_mode_t;

  typedef struct packed {
    logic        seg_writable;
    logic        seg_null;
    logic        seg_limit_bad;
    logic        stack_limit_bad;
    logic        page_miss;
    logic [31:0] page_code;
    logic        unaligned;
    logic [3:0]  io_perm_bits;   // Bitmap bits for port..port+3
  } nnop_chk_t;

  typedef struct packed {
    logic        done;
    logic        claimed;
    logic        wb_valid;
    logic        wb_mem;
    logic [31:0] wb_data;
    nnop_width_t width;
    nnop_flags_t flags;
    nnop_flags_t flags_we;
  } nnop_res_t;

  typedef struct packed {
    logic        valid;
    nnop_vec_t   vector;
    logic        has_code;
    logic [31:0] code;
  } nnop_fault_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [31:0] data;
    nnop_width_t width;
  } nnop_io_t;
endpackage

// file: core/nnop_exec.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "nnop_consts.svh"

// What this block does
// - Opcode 90 is single-byte no-operation
// - No-operation never faults, keeps flags
// - F6/F7 /2 invert destination, no flags
// - Inclusive-or writes dest; 0C/0D accumulator forms
// - Inclusive-or immediate, register, memory encodings
// - Or clears overflow/carry, sets sign/zero/parity
// - Port from imm8 or data count register
// - Port data is accumulator of port width
// - Immediate port address upper byte zero
// - Protected, low privilege: bitmap set faults
// - Virtual-8086 always checks bitmap bits
// - Real or privileged mode writes unchecked
// - Protected, non-V86: nonwritable memory destination faults, no write
// - Protected, non-V86: null data segment selector faults
// - Limit violations give stack or protection fault
// - Page fault and user alignment fault
// - Real mode: no codes, no page/alignment
module nnop_exec
  import nnop_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              issue_valid,
  input  wire nnop_req_t         issue_req,
  input  wire nnop_mode_t        mode,
  input  wire nnop_chk_t         chk,
  output nnop_res_t              result,
  output nnop_fault_t            fault,
  output nnop_io_t               io_write,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   irq
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (ADDR_W < 5) begin : g_bad_addr
    $error("ADDR_W too small for register map");
  end

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Opcode plus extension to instruction class
  function automatic nnop_class_t decode(input logic [7:0] op, input logic [2:0] ext);
    unique case (op)
      `NNOP_OP_NOP: decode = OPC_NOP;
      `NNOP_OP_GRP3_B, `NNOP_OP_GRP3_V:
        decode = (ext == `NNOP_EXT_NOT) ? OPC_NOT : OPC_NONE;
      `NNOP_OP_GRP1_B, `NNOP_OP_GRP1_V, `NNOP_OP_GRP1_SX:
        decode = (ext == `NNOP_EXT_OR) ? OPC_OR : OPC_NONE;
      `NNOP_OP_OR_RM_B, `NNOP_OP_OR_RM_V, `NNOP_OP_OR_R_B, `NNOP_OP_OR_R_V,
      `NNOP_OP_OR_A_B, `NNOP_OP_OR_A_V: decode = OPC_OR;
      `NNOP_OP_OUT_I_B, `NNOP_OP_OUT_I_V, `NNOP_OP_OUT_D_B, `NNOP_OP_OUT_D_V:
        decode = OPC_OUT;
      default: decode = OPC_NONE;
    endcase
  endfunction

  // Data mask for an operand width
  function automatic logic [31:0] wmask(input nnop_width_t w);
    unique case (w)
      W_BYTE:  wmask = 32'h0000_00ff;
      W_WORD:  wmask = 32'h0000_ffff;
      default: wmask = 32'hffff_ffff;
    endcase
  endfunction

  // Sign bit of a value at a width
  function automatic logic msb(input logic [31:0] v, input nnop_width_t w);
    unique case (w)
      W_BYTE:  msb = v[7];
      W_WORD:  msb = v[15];
      default: msb = v[31];
    endcase
  endfunction

  // Bitmap bits covered by a port access
  function automatic logic [3:0] io_cover(input nnop_width_t w);
    unique case (w)
      W_BYTE:  io_cover = 4'h1;
      W_WORD:  io_cover = 4'h3;
      default: io_cover = 4'hf;
    endcase
  endfunction

  // ----------------------------------------
  // Decode and datapath
  // ----------------------------------------
  logic        ctrl_en;
  logic        accept;
  nnop_class_t cls;
  nnop_width_t w;
  logic [7:0]  op;
  logic        or_reg_dest;
  logic        or_acc;
  logic        uses_mem;
  logic        dest_mem;
  logic [31:0] or_dst;
  logic [31:0] or_src;
  logic [31:0] value;
  logic        pm;
  logic        io_check;
  logic        io_deny;
  nnop_fault_t next_fault;

  assign accept = issue_valid && ctrl_en;
  assign op     = issue_req.opcode;
  assign cls    = decode(op, issue_req.ext);
  assign w      = op[0] ? (issue_req.opsize32 ? W_DWORD : W_WORD) : W_BYTE;
  assign or_reg_dest = (op == `NNOP_OP_OR_R_B) || (op == `NNOP_OP_OR_R_V);
  assign or_acc      = (op == `NNOP_OP_OR_A_B) || (op == `NNOP_OP_OR_A_V);
  assign uses_mem = issue_req.rm_is_mem && ((cls == OPC_NOT) || (cls == OPC_OR)) && !or_acc;
  assign dest_mem = uses_mem && !or_reg_dest;
  assign pm       = mode.protection_enable;

  // Operand selection for the or forms
  always_comb begin
    or_dst = issue_req.rm_val;
    or_src = issue_req.reg_val;
    unique case (op)
      `NNOP_OP_OR_R_B, `NNOP_OP_OR_R_V: begin
        or_dst = issue_req.reg_val;
        or_src = issue_req.rm_val;
      end
      `NNOP_OP_OR_A_B, `NNOP_OP_OR_A_V: begin
        or_dst = issue_req.acc_val;
        or_src = issue_req.imm;
      end
      `NNOP_OP_GRP1_B, `NNOP_OP_GRP1_V: or_src = issue_req.imm;
      `NNOP_OP_GRP1_SX: or_src = {{24{issue_req.imm[7]}}, issue_req.imm[7:0]};
      default: or_src = issue_req.reg_val;
    endcase
  end

  // Result value per class
  always_comb begin
    unique case (cls)
      OPC_NOT: value = ~issue_req.rm_val & wmask(w);
      OPC_OR:  value = (or_dst | or_src) & wmask(w);
      OPC_OUT: value = issue_req.acc_val & wmask(w);
      default: value = 32'h0000_0000;
    endcase
  end

  assign io_check = pm && (mode.virtual8086_flag
                    || (mode.current_privilege > mode.io_privilege_level));
  assign io_deny  = io_check && |(chk.io_perm_bits & io_cover(w));

  // Fault selection in priority order
  always_comb begin
    next_fault = '0;
    next_fault.code = `NNOP_ERR_ZERO;
    if (cls == OPC_OUT) begin
      if (io_deny) begin
        next_fault.valid    = 1'b1;
        next_fault.vector   = FLT_GP;
        next_fault.has_code = 1'b1;
      end
    end else if (uses_mem) begin
      if (!pm) begin
        if (chk.seg_limit_bad) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_GP;
        end else if (chk.stack_limit_bad) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_SS;
        end
      end else begin
        next_fault.has_code = 1'b1;
        if ((dest_mem && !chk.seg_writable && !mode.virtual8086_flag)
            || (chk.seg_null && !mode.virtual8086_flag) || chk.seg_limit_bad) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_GP;
        end else if (chk.stack_limit_bad) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_SS;
        end else if (chk.page_miss) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_PF;
          next_fault.code   = chk.page_code;
        end else if (mode.align_check_en && chk.unaligned && (mode.virtual8086_flag
                     || (mode.current_privilege == `NNOP_CPL_USER))) begin
          next_fault.valid  = 1'b1;
          next_fault.vector = FLT_AC;
        end
      end
      if (!next_fault.valid) begin
        next_fault.has_code = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  // Retire record, writeback and flags
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      result <= '0;
    end else begin
      result.done     <= accept;
      result.claimed  <= accept && (cls != OPC_NONE);
      result.wb_valid <= accept && !next_fault.valid && ((cls == OPC_NOT) || (cls == OPC_OR));
      result.wb_mem   <= dest_mem;
      result.wb_data  <= value;
      result.width    <= w;
      result.flags    <= '0;
      result.flags_we <= '0;
      if (accept && !next_fault.valid && (cls == OPC_OR)) begin
        result.flags.sign_flag   <= msb(value, w);
        result.flags.zero_flag   <= (value == 32'h0000_0000);
        result.flags.parity_flag <= ~^value[7:0];
        result.flags_we          <= 6'b111110;
      end
    end
  end

  // Fault report
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fault <= '0;
    end else begin
      fault <= accept ? next_fault : '0;
    end
  end

  // Port write request
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      io_write <= '0;
    end else begin
      io_write.valid <= accept && (cls == OPC_OUT) && !io_deny;
      io_write.addr  <= op[3] ? issue_req.data_count_register : {8'h00, issue_req.imm[7:0]};
      io_write.data  <= value;
      io_write.width <= w;
    end
  end

  // ----------------------------------------
  // Registers and interrupt
  // ----------------------------------------
  logic [3:0]  status;
  logic [3:0]  irq_mask;
  logic [3:0]  events;
  logic [3:0]  next_status;
  logic [31:0] retired;
  logic [31:0] last_fault;
  logic [15:0] last_port;
  logic        rd_status;

  assign events[`NNOP_ST_RETIRE]  = accept && (cls != OPC_NONE) && !next_fault.valid;
  assign events[`NNOP_ST_FAULT]   = accept && next_fault.valid;
  assign events[`NNOP_ST_IOWR]    = accept && (cls == OPC_OUT) && !io_deny;
  assign events[`NNOP_ST_UNCLAIM] = accept && (cls == OPC_NONE);
  assign rd_status   = reg_rd && (reg_addr == ADDR_W'(`NNOP_REG_STATUS));
  // Set wins over read clear
  assign next_status = (rd_status ? 4'h0 : status) | events;

  // Control and mask writes
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_en  <= `NNOP_CTRL_RST;
      irq_mask <= `NNOP_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_W'(`NNOP_REG_CTRL)) begin
        ctrl_en <= reg_wdata[`NNOP_CTRL_EN];
      end
      if (reg_addr == ADDR_W'(`NNOP_REG_MASK)) begin
        irq_mask <= reg_wdata[3:0];
      end
    end
  end

  // Sticky status and interrupt line
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status <= 4'h0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & irq_mask);
    end
  end

  // Retire count and last fault capture
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      retired    <= 32'h0000_0000;
      last_fault <= 32'h0000_0000;
      last_port  <= 16'h0000;
    end else begin
      if (events[`NNOP_ST_RETIRE]) begin
        retired <= retired + 32'h0000_0001;
      end
      if (events[`NNOP_ST_FAULT]) begin
        last_fault <= {13'h0000, next_fault.vector, next_fault.code[15:0]};
      end
      if (events[`NNOP_ST_IOWR]) begin
        last_port <= op[3] ? issue_req.data_count_register : {8'h00, issue_req.imm[7:0]};
      end
    end
  end

  // Read data one cycle after strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_W'(`NNOP_REG_CTRL):    reg_rdata <= {31'h0, ctrl_en};
        ADDR_W'(`NNOP_REG_STATUS):  reg_rdata <= {28'h0, status};
        ADDR_W'(`NNOP_REG_MASK):    reg_rdata <= {28'h0, irq_mask};
        ADDR_W'(`NNOP_REG_RETIRED): reg_rdata <= retired;
        ADDR_W'(`NNOP_REG_FAULT):   reg_rdata <= last_fault;
        ADDR_W'(`NNOP_REG_IOADDR):  reg_rdata <= {16'h0, last_port};
        default:                    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic acc_nop;
  logic acc_not;
  logic acc_or;
  logic acc_outi;
  assign acc_nop  = accept && (cls == OPC_NOP);
  assign acc_not  = accept && (cls == OPC_NOT) && !next_fault.valid;
  assign acc_or   = accept && (cls == OPC_OR) && !next_fault.valid;
  assign acc_outi = accept && (cls == OPC_OUT) && !op[3];

  AST_NOP_QUIET: assert property (@(posedge clock) disable iff (reset)
    acc_nop |=> result.done && !fault.valid && !result.wb_valid
                && (result.flags_we == '0) && !io_write.valid)
    else $error("no-operation changed state");

  AST_NOT_INVERT: assert property (@(posedge clock) disable iff (reset)
    acc_not |=> result.wb_valid && (result.flags_we == '0)
                && (result.wb_data == (~$past(issue_req.rm_val) & wmask(result.width))))
    else $error("inverter result or flags wrong");

  AST_OR_FLAGS: assert property (@(posedge clock) disable iff (reset)
    acc_or |=> result.flags_we.overflow_flag && !result.flags.overflow_flag
               && !result.flags.carry_flag
               && (result.flags.zero_flag == (result.wb_data == 32'h0000_0000)))
    else $error("or flags wrong");

  AST_OR_SEXT: assert property (@(posedge clock) disable iff (reset)
    (acc_or && (op == `NNOP_OP_GRP1_SX) && issue_req.imm[7] && issue_req.opsize32)
    |=> (result.wb_data[31:8] == 24'hff_ffff))
    else $error("byte immediate not sign-extended");

  AST_OUT_IMM_ADDR: assert property (@(posedge clock) disable iff (reset)
    (acc_outi && !io_deny) |=> io_write.valid && (io_write.addr[15:8] == 8'h00))
    else $error("immediate port address high byte not zero");

  AST_V86_IO_DENY: assert property (@(posedge clock) disable iff (reset)
    (accept && (cls == OPC_OUT) && pm && mode.virtual8086_flag
     && |(chk.io_perm_bits & io_cover(w)))
    |=> fault.valid && (fault.vector == FLT_GP) && (fault.code == 32'h0) && !io_write.valid)
    else $error("virtual-8086 port write not refused");

  AST_REAL_IO_OK: assert property (@(posedge clock) disable iff (reset)
    (accept && (cls == OPC_OUT) && !pm) |=> io_write.valid && !fault.valid
                                        && (result.flags_we == '0))
    else $error("real mode port write blocked");

  AST_NONWRITE: assert property (@(posedge clock) disable iff (reset)
    (accept && dest_mem && pm && !mode.virtual8086_flag && !chk.seg_writable)
    |=> fault.valid && (fault.vector == FLT_GP) && fault.has_code && !result.wb_valid)
    else $error("nonwritable destination not faulted");

  AST_REAL_NOCODE: assert property (@(posedge clock) disable iff (reset)
    (accept && uses_mem && !pm) |=> !fault.has_code
        && (fault.vector != FLT_PF) && (fault.vector != FLT_AC))
    else $error("real mode fault carried a code");

  AST_STATUS_SET_WINS: assert property (@(posedge clock) disable iff (reset)
    (rd_status && events[`NNOP_ST_FAULT]) |=> status[`NNOP_ST_FAULT] ##1 1'b1)
    else $error("fault event lost on status clear");

endmodule

`default_nettype wire

// file: sim/nnop_io_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port-space peripheral model
// ----------------------------------------
module nnop_io_sink
  import nnop_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     reset,
  input  wire nnop_io_t io_write,
  output logic [15:0]   last_addr,
  output logic [31:0]   last_data,
  output int            n_writes
);
  // Latch every port write that reaches the port space
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      last_addr <= 16'h0000;
      last_data <= 32'h0000_0000;
      n_writes  <= 0;
    end else if (io_write.valid) begin
      last_addr <= io_write.addr;
      last_data <= io_write.data;
      n_writes  <= n_writes + 1;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nnop_pkg::*;
;
  logic        clock;
  logic        reset;
  logic        issue_valid;
  nnop_req_t   r;
  nnop_mode_t  m;
  nnop_chk_t   c;
  nnop_res_t   result;
  nnop_fault_t fault;
  nnop_io_t    io_write;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic [15:0] sink_addr;
  logic [31:0] sink_data;
  logic [31:0] rv;
  int          sink_n;
  int          num_errors;
  int          n_tests;

  nnop_exec #(.ADDR_W(8)) i_nnop_exec (
    .clock(clock), .reset(reset), .issue_valid(issue_valid), .issue_req(r),
    .mode(m), .chk(c), .result(result), .fault(fault), .io_write(io_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  nnop_io_sink i_nnop_io_sink (
    .clock(clock), .reset(reset), .io_write(io_write),
    .last_addr(sink_addr), .last_data(sink_data), .n_writes(sink_n));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  // 100 ns period
  always #50 clock = ~clock;

  // Compare one value
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Default operands: all checks pass
  task automatic clr;
    r = '0;
    m = '0;
    c = '0;
    c.seg_writable = 1'b1;
  endtask

  // One issue pulse, sample the answer cycle
  task automatic go;
    @(posedge clock);
    issue_valid <= 1'b1;
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
  endtask

  // Register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Final report and end of run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // No-operation with every fault input asserted
  task automatic t_nop;
    clr();
    r.opcode = 8'h90;
    r.rm_is_mem = 1'b1;
    m = '{1'b1, 1'b0, 2'h3, 2'h0, 1'b1};
    c = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 32'h0000_0005, 1'b1, 4'hf};
    go();
    chk("nop_claim", 32'h1, {31'h0, result.done & result.claimed});
    chk("nop_wb", 32'h0, {31'h0, result.wb_valid | io_write.valid});
    chk("nop_flt", 32'h0, {31'h0, fault.valid});
    chk("nop_fwe", 32'h0, {26'h0, result.flags_we});
    $display("test nop done");
  endtask

  // Inversion at each width, plus an unowned extension
  task automatic not_case(input logic [7:0] op, input logic o32, input logic [31:0] v,
                          input logic [31:0] e, input logic [31:0] msk);
    clr();
    r.opcode = op;
    r.ext = 3'h2;
    r.opsize32 = o32;
    r.rm_val = v;
    go();
    chk("not_wb", 32'h1, {31'h0, result.wb_valid});
    chk("not_data", e, result.wb_data & msk);
    chk("not_fwe", 32'h0, {26'h0, result.flags_we});
  endtask

  task automatic t_not;
    not_case(8'hf6, 1'b0, 32'h0000_005a, 32'h0000_00a5, 32'h0000_00ff);
    not_case(8'hf7, 1'b0, 32'h0000_1234, 32'h0000_edcb, 32'h0000_ffff);
    not_case(8'hf7, 1'b1, 32'h0000_0000, 32'hffff_ffff, 32'hffff_ffff);
    r.ext = 3'h3;
    go();
    chk("neg_claim", 32'h0, {31'h0, result.claimed | result.wb_valid});
    $display("test not done");
  endtask

  // Inclusive-or: result and flags from hand-worked values
  task automatic or_case(input logic [7:0] op, input logic o32, input logic [31:0] rmv,
                         input logic [31:0] regv, input logic [31:0] accv,
                         input logic [31:0] immv, input logic [31:0] e);
    logic [31:0] msk;
    logic        sf;
    clr();
    msk = !op[0] ? 32'h0000_00ff : (o32 ? 32'hffff_ffff : 32'h0000_ffff);
    sf  = !op[0] ? e[7] : (o32 ? e[31] : e[15]);
    r = '{op, 3'h1, o32, 1'b0, rmv, regv, accv, immv, 16'h0000};
    go();
    chk("or_data", e & msk, result.wb_data & msk);
    chk("or_flags", {26'h0, 2'b00, sf, (e & msk) == 0, ~^e[7:0], 1'b0},
        {26'h0, result.flags & 6'h3e});
    chk("or_fwe", 32'h3e, {26'h0, result.flags_we & 6'h3e});
  endtask

  task automatic t_or;
    or_case(8'h0c, 1'b0, 32'h0, 32'h0, 32'h0000_0080, 32'h0, 32'h0000_0080);
    or_case(8'h0d, 1'b0, 32'h0, 32'h0, 32'h0000_0000, 32'h0, 32'h0000_0000);
    or_case(8'h0d, 1'b1, 32'h0, 32'h0, 32'h1200_0000, 32'h3, 32'h1200_0003);
    or_case(8'h80, 1'b0, 32'h0000_000f, 32'h0, 32'h0, 32'h30, 32'h0000_003f);
    or_case(8'h81, 1'b1, 32'h8000_0000, 32'h0, 32'h0, 32'h1, 32'h8000_0001);
    or_case(8'h83, 1'b1, 32'h0000_0010, 32'h0, 32'h0, 32'h80, 32'hffff_ff90);
    or_case(8'h83, 1'b0, 32'h0000_0001, 32'h0, 32'h0, 32'h7e, 32'h0000_007f);
    or_case(8'h08, 1'b0, 32'h0000_0001, 32'h2, 32'h0, 32'h0, 32'h0000_0003);
    or_case(8'h09, 1'b0, 32'h0000_8100, 32'h1, 32'h0, 32'h0, 32'h0000_8101);
    or_case(8'h0a, 1'b0, 32'h0000_0004, 32'h40, 32'h0, 32'h0, 32'h0000_0044);
    or_case(8'h0b, 1'b1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0000);
    $display("test or done");
  endtask

  // Port write under a mode; deny selects a fault in place of the write
  task automatic out_case(input logic [7:0] op, input logic o32, input logic [4:0] md,
                          input logic [3:0] pb, input logic deny,
                          input logic [15:0] ea, input logic [31:0] ed);
    clr();
    r = '{op, 3'h0, o32, 1'b0, 32'h0, 32'h0, 32'haabb_ccdd, 32'h0000_1234, 16'hfedc};
    m = '{md[4], md[3], md[2:1], 2'h1, md[0]};
    c.io_perm_bits = pb;
    go();
    chk("out_valid", {31'h0, !deny}, {31'h0, io_write.valid});
    chk("out_gp", {deny, 31'h0}, {fault.valid, 31'h0});
    if (deny)
      chk("out_code", {4'h1, 28'h0}, {1'b0, fault.vector, fault.code[27:0]});
    else begin
      chk("out_addr", {16'h0, ea}, {16'h0, io_write.addr});
      chk("out_data", ed, io_write.data);
      @(posedge clock);
      #1;
      chk("sink_addr", {16'h0, ea}, {16'h0, sink_addr});
    end
  endtask

  task automatic t_out;
    out_case(8'he6, 1'b0, 5'h00, 4'h0, 1'b0, 16'h0034, 32'h0000_00dd);
    out_case(8'he7, 1'b0, 5'h00, 4'h0, 1'b0, 16'h0034, 32'h0000_ccdd);
    out_case(8'hee, 1'b0, 5'h00, 4'h0, 1'b0, 16'hfedc, 32'h0000_00dd);
    out_case(8'hef, 1'b1, 5'h00, 4'h0, 1'b0, 16'hfedc, 32'haabb_ccdd);
    out_case(8'hee, 1'b0, 5'h14, 4'h1, 1'b1, 16'h0, 32'h0);
    out_case(8'hee, 1'b0, 5'h14, 4'h0, 1'b0, 16'hfedc, 32'h0000_00dd);
    out_case(8'hef, 1'b1, 5'h10, 4'h8, 1'b0, 16'hfedc, 32'haabb_ccdd);
    out_case(8'hee, 1'b0, 5'h18, 4'h1, 1'b1, 16'h0, 32'h0);
    out_case(8'hee, 1'b0, 5'h04, 4'hf, 1'b0, 16'hfedc, 32'h0000_00dd);
    $display("test out done");
  endtask

  // Memory destination faults; sel picks the failing check
  task automatic mem_case(input logic [7:0] op, input logic [4:0] md, input int sel,
                          input logic [3:0] ev, input logic hc);
    clr();
    r = '{op, 3'h1, 1'b1, 1'b1, 32'h1, 32'h2, 32'h0, 32'h4, 16'h0};
    m = '{md[4], md[3], md[2:1], 2'h0, md[0]};
    c = '{sel != 0, sel == 1, sel == 2, sel == 3, sel == 4, 32'h0000_0006, sel == 5, 4'h0};
    go();
    chk("mem_flt", {ev, hc}, {1'b0, fault.vector, fault.valid & fault.has_code});
    if (ev != 0)
      chk("mem_code", (ev == 4'h3) ? 32'h6 : 32'h0, fault.code & {32{hc}});
    chk("mem_wb", {31'h0, ev == 0}, {31'h0, result.wb_valid});
  endtask

  task automatic t_mem;
    mem_case(8'h08, 5'h10, 0, 4'h1, 1'b1);
    mem_case(8'h0a, 5'h10, 0, 4'h0, 1'b0);
    mem_case(8'h80, 5'h10, 1, 4'h1, 1'b1);
    mem_case(8'h81, 5'h10, 2, 4'h1, 1'b1);
    mem_case(8'h81, 5'h10, 3, 4'h2, 1'b1);
    mem_case(8'h81, 5'h18, 3, 4'h2, 1'b1);
    mem_case(8'h83, 5'h10, 4, 4'h3, 1'b1);
    mem_case(8'h83, 5'h17, 5, 4'h4, 1'b1);
    mem_case(8'h83, 5'h11, 5, 4'h0, 1'b0);
    mem_case(8'h09, 5'h07, 2, 4'h1, 1'b0);
    mem_case(8'h09, 5'h07, 3, 4'h2, 1'b0);
    mem_case(8'h09, 5'h07, 4, 4'h0, 1'b0);
    $display("test mem done");
  endtask

  // Status, mask, interrupt, unmapped read, disable
  task automatic t_regs;
    rd(8'h04, rv);
    wr(8'h08, 32'h1);
    not_case(8'hf6, 1'b0, 32'h0, 32'h0000_00ff, 32'h0000_00ff);
    @(posedge clock);
    chk("irq_on", 32'h1, {31'h0, irq});
    rd(8'h04, rv);
    chk("status", 32'h1, rv & 32'hf);
    rd(8'h04, rv);
    chk("status_clr", 32'h0, rv & 32'hf);
    chk("irq_off", 32'h0, {31'h0, irq});
    rd(8'h3c, rv);
    chk("unmapped", 32'h0, rv);
    wr(8'h00, 32'h0);
    go();
    chk("disabled", 32'h0, {31'h0, result.done});
    wr(8'h00, 32'h1);
    $display("test regs done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    issue_valid = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    num_errors = 0;
    n_tests = 0;
    clr();
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_nop();
    t_not();
    t_or();
    t_out();
    t_mem();
    t_regs();
    give_verdict();
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
